// [nvisb_params.svh]
`ifndef NVISB_PARAMS_SVH
`define NVISB_PARAMS_SVH

// sizes
`define NVISB_NUM_IRQ       81
`define NVISB_ADDR_W        12
`define NVISB_DATA_W        32
`define NVISB_PRIO_W        4
`define NVISB_NUM_W         7
`define NVISB_SPLIT_W       3
`define NVISB_SPLIT_MAX     3'h4

// register block bases, byte addresses
`define NVISB_OFS_ENA_SET   12'h000
`define NVISB_OFS_ENA_CLR   12'h080
`define NVISB_OFS_PND_SET   12'h100
`define NVISB_OFS_PND_CLR   12'h180
`define NVISB_OFS_ACT       12'h200
`define NVISB_OFS_PRIO      12'h300
`define NVISB_OFS_CFG       12'h400

// region select and word index fields of the byte address
`define NVISB_REGION_HI     11
`define NVISB_REGION_LO     7
`define NVISB_INDEX_HI      6
`define NVISB_INDEX_LO      2

// field layout inside an 8-bit priority byte
`define NVISB_PRIO_LSB      4

// reset values
`define NVISB_RST_WORD      32'h0000_0000
`define NVISB_RST_PRIO      4'h0
`define NVISB_RST_SPLIT     3'h0

`endif

// [nvisb_pkg.sv]
package nvisb_pkg;

    // bus answer sequencer
    typedef enum logic [1:0] {
        NVISB_BUS_IDLE = 2'b01,
        NVISB_BUS_ACK  = 2'b10
    } nvisb_bus_t;

    // register blocks reachable over the bus
    typedef enum logic [6:0] {
        NVISB_REG_NONE    = 7'b0000001,
        NVISB_REG_ENA_SET = 7'b0000010,
        NVISB_REG_ENA_CLR = 7'b0000100,
        NVISB_REG_PND_SET = 7'b0001000,
        NVISB_REG_PND_CLR = 7'b0010000,
        NVISB_REG_ACT     = 7'b0100000,
        NVISB_REG_PRIO    = 7'b1000000
    } nvisb_reg_t;

endpackage

// [nvisb_top.sv]
// Operation
// - up to 81 peripheral lines, each with own enable, pending, active bit
// - four-bit priority per line, lower value is more urgent
// - request lines accepted both as held levels and as pulses
// - priority splits into group and subpriority, changeable at run time
// - one non-maskable request input that no enable bit can block
// - core stacks and unstacks its state itself on entry and exit
// - one bit per line, word n/32, bit n mod 32
// - enable-set write 1 enables, 0 no effect, read shows enables
// - pending and enabled lines are offered to the core by priority
// - disabled line still goes pending but is never offered
// - enable-clear write 1 disables, 0 no effect, read shows enables
// - pending-set write 1 makes pending, read shows pending
// - setting an already pending line changes nothing
// - setting pending on a disabled line still makes it pending
// - pending-clear write 1 removes pending, read shows pending
// - pending-clear leaves active state alone
// - active array is read only, shows active or active and pending
// - all state arrays read zero after reset
// - one 8-bit priority byte per line, byte n for line n
// - pending on line high while inactive, or on a rising edge
// - entry moves pending to active; exit re-pends a still-high level
// - only top four bits of each priority byte stored, low four read zero
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
`include "nvisb_params.svh"

module nvisb_top #(
    parameter int NUM_IRQ = `NVISB_NUM_IRQ
) (
    // clock and reset
    input  wire logic                        CLK,
    input  wire logic                        NRST,
    // avalon-mm slave
    input  wire logic [`NVISB_ADDR_W-1:0]    AVS_ADDRESS,
    input  wire logic                        AVS_READ,
    input  wire logic                        AVS_WRITE,
    input  wire logic [`NVISB_DATA_W-1:0]    AVS_WRITEDATA,
    input  wire logic [3:0]                  AVS_BYTEENABLE,
    output logic      [`NVISB_DATA_W-1:0]    AVS_READDATA,
    output logic                             AVS_WAITREQUEST,
    // peripheral request lines
    input  wire logic [NUM_IRQ-1:0]          IRQ_LINES,
    input  wire logic                        NMI_LINE,
    // processor core side
    output logic                             NMI_REQ,
    output logic                             IRQ_REQ,
    output logic      [`NVISB_NUM_W-1:0]     IRQ_NUM,
    output logic      [`NVISB_PRIO_W-1:0]    IRQ_PRIO,
    input  wire logic                        IRQ_ENTER,
    input  wire logic [`NVISB_NUM_W-1:0]     IRQ_ENTER_NUM,
    input  wire logic                        IRQ_EXIT,
    input  wire logic [`NVISB_NUM_W-1:0]     IRQ_EXIT_NUM
);

    localparam int WORDS = (NUM_IRQ + 31) / 32;
    localparam int PW    = WORDS * 32;

    // state arrays
    logic [NUM_IRQ-1:0]              en_q;
    logic [NUM_IRQ-1:0]              pend_q;
    logic [NUM_IRQ-1:0]              act_q;
    logic [`NVISB_PRIO_W-1:0]        prio_q [NUM_IRQ];
    logic [`NVISB_SPLIT_W-1:0]       split_q;

    // synchronisers
    logic [NUM_IRQ-1:0]              line_m_q;
    logic [NUM_IRQ-1:0]              line_s_q;
    logic [NUM_IRQ-1:0]              line_p_q;
    logic                            nmi_m_q;
    logic                            nmi_s_q;

    // bus
    nvisb_pkg::nvisb_bus_t           bus_q;
    nvisb_pkg::nvisb_reg_t           sel;
    logic [4:0]                      widx;
    logic                            cfg_hit;
    logic                            wr_go;
    logic [31:0]                     wmask;
    logic [31:0]                     wbits;
    logic [31:0]                     rd_d;

    // group part of a priority under the current split
    function automatic logic [`NVISB_PRIO_W-1:0] grp_of(
        input logic [`NVISB_PRIO_W-1:0]  p,
        input logic [`NVISB_SPLIT_W-1:0] s
    );
        logic [`NVISB_PRIO_W-1:0] m;
        m = 4'hf << ((s > `NVISB_SPLIT_MAX) ? `NVISB_SPLIT_MAX : s);
        return p & m;
    endfunction

    // place a 32-bit word into the state vector, dropping missing lines
    function automatic logic [NUM_IRQ-1:0] place(
        input logic [31:0] w,
        input logic [4:0]  idx
    );
        logic [PW-1:0] v;
        v = '0;
        if (int'(idx) < WORDS) begin
            v[int'(idx)*32 +: 32] = w;
        end
        return v[NUM_IRQ-1:0];
    endfunction

    // pick a 32-bit word out of a state vector, zero beyond the count
    function automatic logic [31:0] pick(
        input logic [NUM_IRQ-1:0] vec,
        input logic [4:0]         idx
    );
        logic [PW-1:0] v;
        v = '0;
        v[NUM_IRQ-1:0] = vec;
        if (int'(idx) < WORDS) begin
            return v[int'(idx)*32 +: 32];
        end
        return `NVISB_RST_WORD;
    endfunction

    // one-hot line select from a number
    function automatic logic [NUM_IRQ-1:0] hit_of(
        input logic                    go,
        input logic [`NVISB_NUM_W-1:0] n
    );
        logic [NUM_IRQ-1:0] h;
        h = '0;
        for (int i = 0; i < NUM_IRQ; i++) begin
            if (go && int'(n) == i) begin
                h[i] = 1'b1;
            end
        end
        return h;
    endfunction

    // address decode
    always_comb begin
        widx    = AVS_ADDRESS[`NVISB_INDEX_HI:`NVISB_INDEX_LO];
        cfg_hit = (AVS_ADDRESS == `NVISB_OFS_CFG);
        unique case (AVS_ADDRESS[`NVISB_REGION_HI:`NVISB_REGION_LO])
            `NVISB_OFS_ENA_SET >> `NVISB_REGION_LO: sel = nvisb_pkg::NVISB_REG_ENA_SET;
            `NVISB_OFS_ENA_CLR >> `NVISB_REGION_LO: sel = nvisb_pkg::NVISB_REG_ENA_CLR;
            `NVISB_OFS_PND_SET >> `NVISB_REGION_LO: sel = nvisb_pkg::NVISB_REG_PND_SET;
            `NVISB_OFS_PND_CLR >> `NVISB_REGION_LO: sel = nvisb_pkg::NVISB_REG_PND_CLR;
            `NVISB_OFS_ACT     >> `NVISB_REGION_LO: sel = nvisb_pkg::NVISB_REG_ACT;
            `NVISB_OFS_PRIO    >> `NVISB_REGION_LO: sel = nvisb_pkg::NVISB_REG_PRIO;
            default:                                sel = nvisb_pkg::NVISB_REG_NONE;
        endcase
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{AVS_BYTEENABLE[b]}};
        end
        wbits = AVS_WRITEDATA & wmask;
    end

    // one wait state per request; the write lands when waitrequest drops
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & (bus_q == nvisb_pkg::NVISB_BUS_IDLE);
    assign wr_go           = AVS_WRITE & (bus_q == nvisb_pkg::NVISB_BUS_ACK);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            bus_q <= nvisb_pkg::NVISB_BUS_IDLE;
        end else begin
            unique case (bus_q)
                nvisb_pkg::NVISB_BUS_IDLE: begin
                    if (AVS_READ | AVS_WRITE) begin
                        bus_q <= nvisb_pkg::NVISB_BUS_ACK;
                    end
                end
                nvisb_pkg::NVISB_BUS_ACK: begin
                    bus_q <= nvisb_pkg::NVISB_BUS_IDLE;
                end
            endcase
        end
    end

    // read mux
    always_comb begin
        rd_d = `NVISB_RST_WORD;
        unique case (sel)
            nvisb_pkg::NVISB_REG_ENA_SET,
            nvisb_pkg::NVISB_REG_ENA_CLR: rd_d = pick(en_q, widx);
            nvisb_pkg::NVISB_REG_PND_SET,
            nvisb_pkg::NVISB_REG_PND_CLR: rd_d = pick(pend_q, widx);
            nvisb_pkg::NVISB_REG_ACT:     rd_d = pick(act_q, widx);
            nvisb_pkg::NVISB_REG_PRIO: begin
                for (int b = 0; b < 4; b++) begin
                    if (int'(widx) * 4 + b < NUM_IRQ) begin
                        rd_d[b*8 + `NVISB_PRIO_LSB +: 4] = prio_q[int'(widx) * 4 + b];
                    end
                end
            end
            nvisb_pkg::NVISB_REG_NONE: begin
                if (cfg_hit) begin
                    rd_d[`NVISB_SPLIT_W-1:0] = split_q;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            AVS_READDATA <= `NVISB_RST_WORD;
        end else if (AVS_READ && bus_q == nvisb_pkg::NVISB_BUS_IDLE) begin
            AVS_READDATA <= rd_d;
        end
    end

    // input synchronisers and edge history
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            line_m_q <= '0;
            line_s_q <= '0;
            line_p_q <= '0;
            nmi_m_q  <= 1'b0;
            nmi_s_q  <= 1'b0;
            NMI_REQ  <= 1'b0;
        end else begin
            line_m_q <= IRQ_LINES;
            line_s_q <= line_m_q;
            line_p_q <= line_s_q;
            nmi_m_q  <= NMI_LINE;
            nmi_s_q  <= nmi_m_q;
            NMI_REQ  <= nmi_s_q;
        end
    end

    // enable array
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            en_q <= '0;
        end else if (wr_go && sel == nvisb_pkg::NVISB_REG_ENA_SET) begin
            en_q <= en_q | place(wbits, widx);
        end else if (wr_go && sel == nvisb_pkg::NVISB_REG_ENA_CLR) begin
            en_q <= en_q & ~place(wbits, widx);
        end
    end

    // pending and active arrays
    logic [NUM_IRQ-1:0] enter_hit;
    logic [NUM_IRQ-1:0] exit_hit;
    logic [NUM_IRQ-1:0] sw_set;
    logic [NUM_IRQ-1:0] sw_clr;
    logic [NUM_IRQ-1:0] hw_set;

    always_comb begin
        enter_hit = hit_of(IRQ_ENTER, IRQ_ENTER_NUM);
        exit_hit  = hit_of(IRQ_EXIT, IRQ_EXIT_NUM);
        sw_set    = (wr_go && sel == nvisb_pkg::NVISB_REG_PND_SET) ? place(wbits, widx) : '0;
        sw_clr    = (wr_go && sel == nvisb_pkg::NVISB_REG_PND_CLR) ? place(wbits, widx) : '0;
        // level seen while inactive, or any rising edge
        hw_set    = (line_s_q & ~act_q & ~enter_hit) | (line_s_q & ~line_p_q);
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pend_q <= '0;
        end else begin
            // set terms win over clear terms; set on a pending bit is a no-op
            pend_q <= (pend_q & ~sw_clr & ~enter_hit) | hw_set | sw_set;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            act_q <= '0;
        end else begin
            // core stacks on entry and unstacks on exit; these strobes mark it
            act_q <= (act_q | enter_hit) & ~exit_hit;
        end
    end

    // priority bytes and grouping split
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < NUM_IRQ; i++) begin
                prio_q[i] <= `NVISB_RST_PRIO;
            end
        end else if (wr_go && sel == nvisb_pkg::NVISB_REG_PRIO) begin
            for (int b = 0; b < 4; b++) begin
                if (AVS_BYTEENABLE[b] && int'(widx) * 4 + b < NUM_IRQ) begin
                    prio_q[int'(widx) * 4 + b] <= AVS_WRITEDATA[b*8 + `NVISB_PRIO_LSB +: 4];
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            split_q <= `NVISB_RST_SPLIT;
        end else if (wr_go && sel == nvisb_pkg::NVISB_REG_NONE && cfg_hit && AVS_BYTEENABLE[0]) begin
            split_q <= AVS_WRITEDATA[`NVISB_SPLIT_W-1:0];
        end
    end

    // arbitration
    logic                       best_ok;
    logic [`NVISB_NUM_W-1:0]    best_num;
    logic [`NVISB_PRIO_W-1:0]   best_prio;
    logic                       run_ok;
    logic [`NVISB_PRIO_W-1:0]   run_grp;
    logic                       req_d;

    always_comb begin
        best_ok   = 1'b0;
        best_num  = '0;
        best_prio = '0;
        run_ok    = 1'b0;
        run_grp   = '0;
        for (int i = 0; i < NUM_IRQ; i++) begin
            // ascending scan with strict compare keeps the lowest number
            if (pend_q[i] && en_q[i] && (!best_ok || prio_q[i] < best_prio)) begin
                best_ok   = 1'b1;
                best_num  = `NVISB_NUM_W'(i);
                best_prio = prio_q[i];
            end
            if (act_q[i] && (!run_ok || grp_of(prio_q[i], split_q) < run_grp)) begin
                run_ok  = 1'b1;
                run_grp = grp_of(prio_q[i], split_q);
            end
        end
        // only a strictly more urgent group may preempt a running handler
        req_d = best_ok && (!run_ok || grp_of(best_prio, split_q) < run_grp);
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            IRQ_REQ  <= 1'b0;
            IRQ_NUM  <= '0;
            IRQ_PRIO <= '0;
        end else begin
            IRQ_REQ  <= req_d & ~IRQ_ENTER;
            IRQ_NUM  <= best_num;
            IRQ_PRIO <= best_prio;
        end
    end

endmodule

// [nvisb_props.sv]
`timescale 1ns/100ps
`include "nvisb_params.svh"

module nvisb_props #(
    parameter int NUM_IRQ = `NVISB_NUM_IRQ
) (
    // clock and reset
    input wire logic                    CLK,
    input wire logic                    NRST,
    // register bus
    input wire logic                    AVS_READ,
    input wire logic                    AVS_WRITE,
    input wire logic [`NVISB_DATA_W-1:0] AVS_READDATA,
    input wire logic                    AVS_WAITREQUEST,
    // lines and core
    input wire logic                    NMI_LINE,
    input wire logic                    NMI_REQ,
    input wire logic                    IRQ_REQ,
    input wire logic [`NVISB_NUM_W-1:0] IRQ_NUM,
    input wire logic                    IRQ_ENTER
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    wire req = AVS_READ | AVS_WRITE;
    // one access completing, then another request right behind it
    sequence s_done;
        req && !AVS_WAITREQUEST;
    endsequence
    sequence s_next;
        s_done ##1 req;
    endsequence
    property p_wait_idle;
        !req |-> !AVS_WAITREQUEST;
    endproperty
    property p_wait_new;
        s_next |-> AVS_WAITREQUEST;
    endproperty
    property p_wait_rd;
        AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
    endproperty
    property p_wait_wr;
        AVS_WRITE && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
    endproperty
    property p_rdata_hold;
        !AVS_READ |=> $stable(AVS_READDATA);
    endproperty
    property p_nmi;
        NMI_REQ == $past(NMI_LINE, 3);
    endproperty
    property p_enter_drop;
        IRQ_ENTER |=> !IRQ_REQ;
    endproperty
    property p_num_range;
        IRQ_REQ |-> IRQ_NUM < NUM_IRQ;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("wait without request");
    a_wait_new: assert property (p_wait_new) else $error("no wait state");
    a_wait_rd: assert property (p_wait_rd) else $error("read wait too long");
    a_wait_wr: assert property (p_wait_wr) else $error("write wait too long");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    a_nmi: assert property (p_nmi) else $error("nmi request wrong");
    a_enter_drop: assert property (p_enter_drop) else $error("request after entry");
    a_num_range: assert property (p_num_range) else $error("line number too big");
endmodule

bind nvisb_top nvisb_props #(.NUM_IRQ(NUM_IRQ)) u_nvisb_props (
    .CLK(CLK), .NRST(NRST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .NMI_LINE(NMI_LINE), .NMI_REQ(NMI_REQ), .IRQ_REQ(IRQ_REQ),
    .IRQ_NUM(IRQ_NUM), .IRQ_ENTER(IRQ_ENTER)
);

// [nvisb_core.sv]
`timescale 1ns/100ps

module nvisb_core #(
    parameter int HOLD = 40
) (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       en,
    input wire logic       irq_req,
    input wire logic [6:0] irq_num,
    output logic           enter,
    output logic           leave,
    output logic [6:0]     num,
    output logic           busy,
    output int             ent_cnt
);
    int cnt_q;
    // takes the offered line, runs the handler HOLD+1 cycles, returns
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            enter <= 1'h0;
            leave <= 1'h0;
            busy <= 1'h0;
            num <= 7'h00;
            cnt_q <= 0;
            ent_cnt <= 0;
        end else begin
            enter <= 1'h0;
            leave <= 1'h0;
            if (!busy && en && irq_req) begin
                enter <= 1'h1;
                num <= irq_num;
                busy <= 1'h1;
                cnt_q <= HOLD;
                ent_cnt <= ent_cnt + 1;
            end else if (busy && cnt_q != 0) cnt_q <= cnt_q - 1;
            else if (busy) begin
                leave <= 1'h1;
                busy <= 1'h0;
            end
        end
    end
endmodule

// [nvisb_bench.sv]
`timescale 1ns/100ps
`include "nvisb_params.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: %h %h", $time, (a), (e)); end end

module nvisb_bench;
    localparam logic [11:0] ES = `NVISB_OFS_ENA_SET;
    localparam logic [11:0] EC = `NVISB_OFS_ENA_CLR;
    localparam logic [11:0] PS = `NVISB_OFS_PND_SET;
    localparam logic [11:0] PC = `NVISB_OFS_PND_CLR;
    localparam logic [11:0] AC = `NVISB_OFS_ACT;
    localparam logic [11:0] PR = `NVISB_OFS_PRIO;
    logic CLK = 1'h0;
    logic NRST = 1'h0;
    logic [11:0] addr = 12'h000;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] be = 4'hf;
    logic [`NVISB_NUM_IRQ-1:0] lines = 81'h0;
    logic nmi = 1'h0;
    logic en = 1'h0;
    logic held = 1'h0;
    wire [31:0] rdat;
    wire wt, nreq, req, ent, lv, busy;
    wire [6:0] num, cnum;
    wire [3:0] prio;
    int ent_cnt;
    int error_cnt = 0;
    int checked = 0;

    initial begin
        forever #5 CLK = ~CLK;
    end

    nvisb_top #(.NUM_IRQ(`NVISB_NUM_IRQ)) u_nvisb_top (
        .CLK(CLK), .NRST(NRST), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wt), .IRQ_LINES(lines), .NMI_LINE(nmi), .NMI_REQ(nreq),
        .IRQ_REQ(req), .IRQ_NUM(num), .IRQ_PRIO(prio), .IRQ_ENTER(ent),
        .IRQ_ENTER_NUM(cnum), .IRQ_EXIT(lv), .IRQ_EXIT_NUM(cnum));
    nvisb_core #(.HOLD(40)) u_nvisb_core (
        .clk(CLK), .nrst(NRST), .en(en), .irq_req(req), .irq_num(num), .enter(ent),
        .leave(lv), .num(cnum), .busy(busy), .ent_cnt(ent_cnt));

    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic tmo(input logic ok);
        if (!ok) begin
            `CHK(ok, 1'h1)
            conclude();
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, input logic h);
        logic bw;
        int n;
        bw = 1'h1;
        if (!held) @(posedge CLK);
        addr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        for (n = 0; n < 20 && bw; n++) begin
            @(posedge CLK);
            bw = wt;
            q = rdat;
        end
        tmo(!bw);
        held = h;
        if (!h) begin
            wr <= 1'h0;
            rd <= 1'h0;
        end
    endtask

    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q, 1'h0);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q, 1'h0);
        `CHK(q, e)
    endtask

    task automatic seen(input logic [6:0] n, input logic [3:0] p);
        int k;
        for (k = 0; k < 8; k++) begin
            @(negedge CLK);
            if (req === 1'h1 && num === n) break;
        end
        `CHK(num, n)
        `CHK(prio, p)
        @(posedge CLK);
    endtask

    task automatic waitent(input int c);
        int n;
        for (n = 0; n < 100 && ent_cnt < c; n++) @(posedge CLK);
        tmo(ent_cnt >= c);
    endtask

    task automatic t_reset;
        int i;
        for (i = 0; i < 3; i++) begin
            rchk(ES + 12'(4 * i), 32'h0);
            rchk(PS + 12'(4 * i), 32'h0);
            rchk(AC + 12'(4 * i), 32'h0);
        end
        $display("test reset done");
    endtask

    task automatic t_enable;
        logic [31:0] q;
        bus(1'h1, ES + 12'h008, 32'hffffffff, q, 1'h1);
        rchk(ES + 12'h008, 32'h0001ffff);
        rchk(EC + 12'h008, 32'h0001ffff);
        wr32(EC + 12'h008, 32'h00000001);
        wr32(ES + 12'h008, 32'h0);
        rchk(ES + 12'h008, 32'h0001fffe);
        wr32(ES + 12'h004, 32'h00000010);
        rchk(EC + 12'h004, 32'h00000010);
        rchk(ES, 32'h0);
        wr32(EC + 12'h004, 32'hffffffff);
        wr32(EC + 12'h008, 32'hffffffff);
        rchk(ES + 12'h008, 32'h0);
        $display("test enable done");
    endtask

    task automatic t_pend;
        wr32(PS + 12'h004, 32'h80000001);
        wr32(PS + 12'h004, 32'h80000001);
        lines[40] <= 1'h1;
        @(posedge CLK);
        lines[40] <= 1'h0;
        repeat (5) @(posedge CLK);
        rchk(PS + 12'h004, 32'h80000101);
        @(negedge CLK);
        `CHK(req, 1'h0)
        wr32(PC + 12'h004, 32'h00000001);
        rchk(PC + 12'h004, 32'h80000100);
        wr32(PC + 12'h004, 32'hffffffff);
        rchk(PS + 12'h004, 32'h0);
        $display("test pending done");
    endtask

    task automatic t_prio;
        wr32(PR, 32'h12345678);
        rchk(PR, 32'h10305070);
        be <= 4'h2;
        wr32(PR + 12'h004, 32'hffffffff);
        be <= 4'hf;
        rchk(PR + 12'h004, 32'h0000f000);
        wr32(PR + 12'h004, 32'h0);
        wr32(PR + 12'h050, 32'hffffffff);
        rchk(PR + 12'h050, 32'h000000f0);
        wr32(ES, 32'h000000ff);
        wr32(PS, 32'h00000006);
        seen(7'h02, 4'h3);
        wr32(PS, 32'h00000030);
        seen(7'h04, 4'h0);
        wr32(PC, 32'h00000010);
        seen(7'h05, 4'h0);
        wr32(PC, 32'h000000ff);
        wr32(EC, 32'h000000f7);
        $display("test priority done");
    endtask

    task automatic t_core;
        int n;
        lines[3] <= 1'h1;
        en <= 1'h1;
        waitent(1);
        rchk(AC, 32'h00000008);
        rchk(PS, 32'h0);
        wr32(AC, 32'hffffffff);
        rchk(AC, 32'h00000008);
        wr32(PS, 32'h00000008);
        wr32(PC, 32'h00000008);
        rchk(AC, 32'h00000008);
        waitent(2);
        lines[3] <= 1'h0;
        for (n = 0; n < 100 && busy !== 1'h0; n++) @(posedge CLK);
        tmo(busy === 1'h0);
        repeat (4) @(posedge CLK);
        rchk(AC, 32'h0);
        rchk(PS, 32'h0);
        en <= 1'h0;
        $display("test core done");
    endtask

    task automatic t_nmi;
        nmi <= 1'h1;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        `CHK(nreq, 1'h1)
        @(posedge CLK);
        nmi <= 1'h0;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        `CHK(nreq, 1'h0)
        $display("test nmi done");
    endtask

    initial begin
        repeat (6) @(posedge CLK);
        NRST <= 1'h1;
        @(posedge CLK);
        t_reset();
        t_enable();
        t_pend();
        t_prio();
        t_core();
        t_nmi();
        conclude();
    end
endmodule
